// *** design/stt_cfg.svh ***
`ifndef STT_CFG_SVH
`define STT_CFG_SVH
// ==========================================
// Register indices (byte address is index * 4)
`define STT_IDX_CTRL 10'h0d1
`define STT_IDX_RELH 10'h0d2
`define STT_IDX_RELL 10'h0d3
`define STT_IDX_CNTH 10'h0d4
`define STT_IDX_CNTL 10'h0d5
`define STT_IDX_PWR 10'h0d6
`define STT_IDX_OSC 10'h0d7
`define STT_IDX_DIV 10'h0d8
`define STT_IDX_STAT 10'h0d9
`define STT_IDX_MASK 10'h0da
// ==========================================
// Field positions
`define STT_CTRL_FLAG 7
`define STT_CTRL_SEL_HI 6
`define STT_CTRL_SEL_LO 5
`define STT_CTRL_IRQ_EN 1
`define STT_CTRL_RUN 0
`define STT_PWR_DOWN 7
`define STT_OSC_RC_BIT 3
`define STT_STAT_RELOAD 0
`define STT_STAT_START 1
`define STT_NSTAT 2
// ==========================================
// Reset values and encodings
`define STT_SEL_RST 2'h3
`define STT_SEL_DIV 2'h3
`define STT_SEL_HF 2'h0
`define STT_SEL_MF 2'h1
`define STT_BYTE_RST 8'h00
`define STT_OSCILLATOR_CONFIG_RST 3'h0
`define STT_OSCILLATOR_CONFIG_HF 3'h0
`define STT_OSCILLATOR_CONFIG_MF 3'h1
`define STT_OSCILLATOR_CONFIG_LF 3'h2
`define STT_OSCILLATOR_CONFIG_RC 3'h3
`define STT_OSCILLATOR_CONFIG_WD 3'h4
`define STT_OSCILLATOR_CONFIG_EXT 3'h7
`endif

// *** design/stt_pkg.sv ***
`default_nettype none
package stt_pkg;
    // Oscillator tick enables, one MCLK pulse per source edge
    typedef struct packed {
        logic hf;
        logic mf;
        logic lf;
        logic ext;
        logic rc;
        logic wd;
    } stt_osc_ticks_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } stt_apb_req_t;

    typedef enum logic {
        STT_CNT_IDLE,
        STT_CNT_RUN
    } stt_cnt_state_t;
endpackage
`default_nettype wire

// *** design/stt_counter.sv ***
`default_nettype none
`include "stt_cfg.svh"
module stt_counter #(
    parameter int PRE_W = 7,
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wdt_rst,
    input wire logic enable,
    input wire logic tick,
    input wire logic [CNT_W-1:0] reload,
    output logic [PRE_W+CNT_W-1:0] count,
    output logic reload_pulse,
    output logic start_pulse
);
    import stt_pkg::*;

    stt_cnt_state_t state_r;
    logic [PRE_W+CNT_W-1:0] load_val;
    logic at_zero;

    assign load_val = {reload, {PRE_W{1'b1}}};
    assign at_zero = (count == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= STT_CNT_IDLE;
        end else if (wdt_rst || !enable) begin
            state_r <= STT_CNT_IDLE;
        end else begin
            state_r <= STT_CNT_RUN;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (wdt_rst || !enable) begin
            count <= '0;
        end else if (state_r == STT_CNT_IDLE) begin
            count <= load_val;
        end else if (tick) begin
            count <= at_zero ? load_val : count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_pulse <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            reload_pulse <= !wdt_rst && enable && state_r == STT_CNT_RUN && tick && at_zero;
            start_pulse <= !wdt_rst && enable && state_r == STT_CNT_IDLE;
        end
    end
endmodule
`default_nettype wire

// *** design/stt_clk_sel.sv ***
`default_nettype none
`include "stt_cfg.svh"
module stt_clk_sel #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire stt_pkg::stt_osc_ticks_t osc,
    input wire logic [2:0] oscillator_config,
    input wire logic rc_clk,
    input wire logic [1:0] sel,
    input wire logic [DIV_W-1:0] divider,
    input wire logic enable,
    output logic tick
);
    import stt_pkg::*;

    logic src;
    logic use_div;
    logic crystal;
    logic base;
    logic [DIV_W-1:0] div_cnt_r;

    always_comb begin
        crystal = 1'b1;
        base = 1'b0;
        unique case (oscillator_config)
            `STT_OSCILLATOR_CONFIG_HF: base = osc.hf;
            `STT_OSCILLATOR_CONFIG_MF: base = osc.mf;
            `STT_OSCILLATOR_CONFIG_LF: base = osc.lf;
            `STT_OSCILLATOR_CONFIG_EXT: base = osc.ext;
            `STT_OSCILLATOR_CONFIG_RC: crystal = 1'b0;
            `STT_OSCILLATOR_CONFIG_WD: crystal = 1'b0;
            default: crystal = 1'b0;
        endcase
        use_div = 1'b0;
        if (sel != `STT_SEL_DIV) begin
            if (crystal) begin
                src = base;
            end else if (sel == `STT_SEL_HF) begin
                src = osc.hf;
            end else if (sel == `STT_SEL_MF) begin
                src = osc.mf;
            end else begin
                src = osc.lf;
            end
        end else if (rc_clk) begin
            src = osc.rc;
        end else begin
            use_div = 1'b1;
            if (crystal) begin
                src = base;
            end else begin
                src = (oscillator_config == `STT_OSCILLATOR_CONFIG_RC) ? osc.rc : osc.wd;
            end
        end
        // Undefined configurations give no counter clock
        if (oscillator_config != `STT_OSCILLATOR_CONFIG_RC && oscillator_config != `STT_OSCILLATOR_CONFIG_WD && !crystal) begin
            src = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
        end else if (!enable || !use_div) begin
            div_cnt_r <= '0;
        end else if (src) begin
            div_cnt_r <= (div_cnt_r >= divider) ? '0 : div_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= enable && src && (!use_div || div_cnt_r >= divider);
        end
    end
endmodule
`default_nettype wire

// *** design/stt_top.sv ***
`default_nettype none
`include "stt_cfg.svh"
module stt_top #(
    parameter int PRE_W = 7,
    parameter int CNT_W = 16,
    parameter int DIV_W = 8
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic WDT_RESET,
    input wire logic WDT_IRQ,
    input wire stt_pkg::stt_osc_ticks_t OSC_TICKS,
    input wire stt_pkg::stt_apb_req_t APB_REQ,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    output logic IRQ,
    output logic SHARED_IRQ
);
    import stt_pkg::*;

    // ==========================================
    // Control and configuration state
    logic flag_r;
    logic [1:0] sel_r;
    logic irq_en_r;
    logic run_r;
    logic pwr_down_r;
    logic [7:0] reload_hi_r;
    logic [7:0] reload_lo_r;
    logic [2:0] oscillator_config_r;
    logic rc_clk_r;
    logic [DIV_W-1:0] div_r;
    logic [`STT_NSTAT-1:0] stat_r;
    logic [`STT_NSTAT-1:0] mask_r;
    logic [`STT_NSTAT-1:0] stat_nxt;
    logic [`STT_NSTAT-1:0] stat_evt;

    // ==========================================
    // Bus decode
    logic [9:0] idx;
    logic aligned;
    logic setup;
    logic wr_commit;
    logic mapped;
    logic [31:0] rdata_nxt;
    logic wr_ctrl;
    logic wr_relh;
    logic wr_rell;
    logic wr_pwr;
    logic wr_osc;
    logic wr_div;
    logic wr_stat;
    logic wr_mask;
    logic [7:0] wbyte;

    // ==========================================
    // Counter path
    logic run_eff;
    logic src_tick;
    logic [PRE_W+CNT_W-1:0] count;
    logic reload_pulse;
    logic start_pulse;

    assign idx = APB_REQ.paddr[11:2];
    assign aligned = (APB_REQ.paddr[1:0] == 2'h0);
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign wr_commit = APB_REQ.psel && APB_REQ.penable && PREADY && APB_REQ.pwrite
        && !PSLVERR;
    assign wbyte = APB_REQ.pwdata[7:0];
    assign wr_ctrl = wr_commit && idx == `STT_IDX_CTRL;
    assign wr_relh = wr_commit && idx == `STT_IDX_RELH;
    assign wr_rell = wr_commit && idx == `STT_IDX_RELL;
    assign wr_pwr = wr_commit && idx == `STT_IDX_PWR;
    assign wr_osc = wr_commit && idx == `STT_IDX_OSC;
    assign wr_div = wr_commit && idx == `STT_IDX_DIV;
    assign wr_stat = wr_commit && idx == `STT_IDX_STAT;
    assign wr_mask = wr_commit && idx == `STT_IDX_MASK;

    assign run_eff = run_r && !pwr_down_r;

    always_comb begin
        mapped = aligned;
        rdata_nxt = 32'h0000_0000;
        unique case (idx)
            `STT_IDX_CTRL: rdata_nxt[7:0] = {flag_r, sel_r, 3'h0, irq_en_r, run_r};
            `STT_IDX_RELH: rdata_nxt[7:0] = reload_hi_r;
            `STT_IDX_RELL: rdata_nxt[7:0] = reload_lo_r;
            `STT_IDX_CNTH: rdata_nxt[7:0] = count[PRE_W+CNT_W-1 -: 8];
            `STT_IDX_CNTL: rdata_nxt[7:0] = count[PRE_W +: 8];
            `STT_IDX_PWR: rdata_nxt[`STT_PWR_DOWN] = pwr_down_r;
            `STT_IDX_OSC: rdata_nxt[3:0] = {rc_clk_r, oscillator_config_r};
            `STT_IDX_DIV: rdata_nxt[DIV_W-1:0] = div_r;
            `STT_IDX_STAT: rdata_nxt[`STT_NSTAT-1:0] = stat_r;
            `STT_IDX_MASK: rdata_nxt[`STT_NSTAT-1:0] = mask_r;
            default: mapped = 1'b0;
        endcase
    end

    // ==========================================
    // APB slave: no wait state, answer registered
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            if (setup) begin
                PRDATA <= (mapped && !APB_REQ.pwrite) ? rdata_nxt : 32'h0000_0000;
                PSLVERR <= !mapped;
            end else if (PREADY) begin
                PRDATA <= 32'h0000_0000;
                PSLVERR <= 1'b0;
            end
        end
    end

    // ==========================================
    // Control register
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_r <= `STT_SEL_RST;
            irq_en_r <= 1'b0;
            run_r <= 1'b0;
        end else if (WDT_RESET) begin
            sel_r <= `STT_SEL_RST;
            irq_en_r <= 1'b0;
            run_r <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_r <= wbyte[`STT_CTRL_IRQ_EN];
            run_r <= wbyte[`STT_CTRL_RUN];
            // Select is locked while running
            if (!run_r) begin
                sel_r <= wbyte[`STT_CTRL_SEL_HI:`STT_CTRL_SEL_LO];
            end
        end
    end

    // Flag: hardware set wins over a software clear
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_r <= 1'b0;
        end else if (WDT_RESET) begin
            flag_r <= 1'b0;
        end else if (reload_pulse) begin
            flag_r <= 1'b1;
        end else if (wr_ctrl && !wbyte[`STT_CTRL_FLAG]) begin
            flag_r <= 1'b0;
        end
    end

    // ==========================================
    // Reload, power and clock configuration
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            reload_hi_r <= `STT_BYTE_RST;
            reload_lo_r <= `STT_BYTE_RST;
        end else if (WDT_RESET) begin
            reload_hi_r <= `STT_BYTE_RST;
            reload_lo_r <= `STT_BYTE_RST;
        end else begin
            if (wr_relh) begin
                reload_hi_r <= wbyte;
            end
            if (wr_rell) begin
                reload_lo_r <= wbyte;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pwr_down_r <= 1'b0;
        end else if (WDT_RESET) begin
            pwr_down_r <= 1'b0;
        end else if (wr_pwr) begin
            pwr_down_r <= wbyte[`STT_PWR_DOWN];
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            oscillator_config_r <= `STT_OSCILLATOR_CONFIG_RST;
            rc_clk_r <= 1'b0;
            div_r <= '0;
        end else if (WDT_RESET) begin
            oscillator_config_r <= `STT_OSCILLATOR_CONFIG_RST;
            rc_clk_r <= 1'b0;
            div_r <= '0;
        end else begin
            if (wr_osc) begin
                oscillator_config_r <= wbyte[2:0];
                rc_clk_r <= wbyte[`STT_OSC_RC_BIT];
            end
            if (wr_div) begin
                div_r <= APB_REQ.pwdata[DIV_W-1:0];
            end
        end
    end

    // ==========================================
    // Event status and mask
    assign stat_evt = {start_pulse, reload_pulse};

    always_comb begin
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~APB_REQ.pwdata[`STT_NSTAT-1:0];
        end
        stat_nxt = stat_nxt | stat_evt;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            stat_r <= '0;
        end else if (WDT_RESET) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_r <= '0;
        end else if (WDT_RESET) begin
            mask_r <= '0;
        end else if (wr_mask) begin
            mask_r <= APB_REQ.pwdata[`STT_NSTAT-1:0];
        end
    end

    // ==========================================
    // Interrupt outputs
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
            SHARED_IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_r & mask_r);
            SHARED_IRQ <= (flag_r && irq_en_r) || WDT_IRQ;
        end
    end

    // ==========================================
    // Clock source and counter
    stt_clk_sel #(
        .DIV_W(DIV_W)
    ) u_clk_sel (
        .clk(MCLK),
        .rst_n(RESETN),
        .osc(OSC_TICKS),
        .oscillator_config(oscillator_config_r),
        .rc_clk(rc_clk_r),
        .sel(sel_r),
        .divider(div_r),
        .enable(run_eff),
        .tick(src_tick)
    );

    stt_counter #(
        .PRE_W(PRE_W),
        .CNT_W(CNT_W)
    ) u_counter (
        .clk(MCLK),
        .rst_n(RESETN),
        .wdt_rst(WDT_RESET),
        .enable(run_eff),
        .tick(src_tick),
        .reload({reload_hi_r, reload_lo_r}),
        .count(count),
        .reload_pulse(reload_pulse),
        .start_pulse(start_pulse)
    );
endmodule
`default_nettype wire

// *** dv/stt_properties.sv ***
`default_nettype none
`include "stt_cfg.svh"
module stt_properties #(
    parameter int PRE_W = 7,
    parameter int CNT_W = 16,
    parameter int DIV_W = 8
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic WDT_RESET,
    input wire logic WDT_IRQ,
    input wire stt_pkg::stt_osc_ticks_t OSC_TICKS,
    input wire stt_pkg::stt_apb_req_t APB_REQ,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic SHARED_IRQ
);
    import stt_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    logic setup;
    logic bad;
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign bad = APB_REQ.paddr[1:0] != 2'b00 || APB_REQ.paddr[11:2] < `STT_IDX_CTRL ||
        APB_REQ.paddr[11:2] > `STT_IDX_MASK;
    // ==========================================
    // Register bus answer
    chk_ready_after_setup: assert property (setup |=> PREADY)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_idle_data_zero: assert property (!PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
        else $error("data or error outside access");
    chk_byte_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_bad_addr_err: assert property (setup && bad |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("bad address not refused");
    chk_good_addr_ok: assert property (setup && !bad |=> !PSLVERR)
        else $error("mapped address refused");
    // ==========================================
    // Interrupt lines
    chk_shared_wdt_irq: assert property (WDT_IRQ |=> SHARED_IRQ)
        else $error("watchdog request not shared");
    chk_wdt_quiets_irq: assert property (WDT_RESET && !WDT_IRQ ##1 !WDT_IRQ
        |=> !SHARED_IRQ && !IRQ)
        else $error("interrupt survives watchdog reset");
endmodule
bind stt_top stt_properties #(.PRE_W(PRE_W), .CNT_W(CNT_W), .DIV_W(DIV_W)) stt_properties_i (
    .MCLK(MCLK), .RESETN(RESETN), .WDT_RESET(WDT_RESET), .WDT_IRQ(WDT_IRQ),
    .OSC_TICKS(OSC_TICKS), .APB_REQ(APB_REQ), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .SHARED_IRQ(SHARED_IRQ));
`default_nettype wire

// *** dv/stt_tb_top.sv ***
`default_nettype none
`include "stt_cfg.svh"
`define STT_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module stt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import stt_pkg::*;
    typedef struct packed {
        logic [3:0] osc;
        logic [1:0] sel;
        logic [7:0] div;
        logic [5:0] src;
        logic [9:0] cyc;
    } stt_case_t;
    // Source masks: hf 20, mf 10, lf 08, ext 04, rc 02, wd 01
    localparam stt_case_t CASES [14] = '{
        '{4'h0, 2'h0, 8'h00, 6'h20, 10'h0c8}, '{4'h1, 2'h1, 8'h00, 6'h10, 10'h0c8},
        '{4'h2, 2'h2, 8'h00, 6'h08, 10'h0c8}, '{4'h0, 2'h3, 8'h03, 6'h20, 10'h2bc},
        '{4'h3, 2'h0, 8'h00, 6'h20, 10'h0c8}, '{4'h3, 2'h1, 8'h00, 6'h10, 10'h0c8},
        '{4'h4, 2'h2, 8'h00, 6'h08, 10'h0c8}, '{4'h3, 2'h3, 8'h03, 6'h02, 10'h2bc},
        '{4'h4, 2'h3, 8'h03, 6'h01, 10'h2bc}, '{4'h7, 2'h1, 8'h00, 6'h04, 10'h0c8},
        '{4'h7, 2'h3, 8'h03, 6'h04, 10'h2bc}, '{4'h8, 2'h3, 8'h03, 6'h02, 10'h0c8},
        '{4'hb, 2'h2, 8'h00, 6'h08, 10'h0c8}, '{4'h5, 2'h0, 8'h00, 6'h00, 10'h0c8}};
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic wdt_reset = 1'b0;
    logic wdt_irq = 1'b0;
    logic [5:0] src = 6'h00;
    stt_osc_ticks_t ticks = '0;
    stt_apb_req_t req = '0;
    logic pready, pslverr, irq, shared_irq;
    logic [31:0] prdata, rdv;
    logic errv;
    logic [7:0] exp8;
    int errors = 0;
    int n_compared = 0;

    always #5 mclk = ~mclk;
    always @(posedge mclk) ticks <= stt_osc_ticks_t'(src);

    stt_top stt_top_i (
        .MCLK(mclk), .RESETN(resetn), .WDT_RESET(wdt_reset), .WDT_IRQ(wdt_irq),
        .OSC_TICKS(ticks), .APB_REQ(req), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .IRQ(irq), .SHARED_IRQ(shared_irq));

    // ==========================================
    // Bus tasks
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        req <= '0;
        // Idle cycle keeps the next setup off the release step
        @(posedge mclk);
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, {i, 2'b00}, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [9:0] i);
        apb(1'b0, {i, 2'b00}, 32'h0000_0000);
    endtask
    // Interrupt pins looked at mid-cycle
    task automatic pins(input logic [1:0] e);
        @(posedge mclk);
        @(negedge mclk);
        `STT_CHK({irq, shared_irq}, e)
        @(posedge mclk);
    endtask
    task automatic wrap_up();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        wrap_up();
    end

    // ==========================================
    // Tests
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (int i = 'h0d1; i <= 'h0da; i++) begin
            rd(10'(i));
            `STT_CHK(rdv, (i == 'h0d1) ? 32'h0000_0060 : 32'h0000_0000)
        end
        rd(10'h0db);
        `STT_CHK({errv, rdv}, 33'h0_0000_0000 | 33'h1_0000_0000)
        apb(1'b0, 12'h345, 32'h0000_0000);
        `STT_CHK(errv, 1'b1)
        wr(`STT_IDX_RELH, 8'ha5);
        wr(`STT_IDX_RELL, 8'h3c);
        rd(`STT_IDX_CNTH);
        `STT_CHK(rdv, 32'h0000_0000)
        wr(`STT_IDX_CTRL, 8'h01);
        rd(`STT_IDX_CNTH);
        `STT_CHK(rdv, 32'h0000_00a5)
        rd(`STT_IDX_CNTL);
        `STT_CHK(rdv, 32'h0000_003c)
        rd(`STT_IDX_STAT);
        `STT_CHK(rdv, 32'h0000_0002)
        wr(`STT_IDX_PWR, 8'h80);
        rd(`STT_IDX_CNTL);
        `STT_CHK(rdv, 32'h0000_0000)
        rd(`STT_IDX_RELH);
        `STT_CHK(rdv, 32'h0000_00a5)
        wr(`STT_IDX_PWR, 8'h00);
        wr(`STT_IDX_CTRL, 8'h00);
        wr(`STT_IDX_STAT, 8'h03);
        wr(`STT_IDX_RELH, 8'h00);
        wr(`STT_IDX_RELL, 8'h01);
        // Counter moves only from the chosen source
        foreach (CASES[k]) begin
            wr(`STT_IDX_OSC, {4'h0, CASES[k].osc});
            wr(`STT_IDX_DIV, CASES[k].div);
            for (int p = 0; p < 2; p++) begin
                src <= (p == 0) ? CASES[k].src : ~CASES[k].src;
                wr(`STT_IDX_CTRL, {1'b0, CASES[k].sel, 5'b0_0001});
                repeat (CASES[k].cyc) @(posedge mclk);
                rd(`STT_IDX_CNTL);
                exp8 = (p == 0 && CASES[k].src != 0) ? 8'h00 : 8'h01;
                `STT_CHK(rdv[7:0], exp8)
                wr(`STT_IDX_CTRL, 8'h00);
            end
        end
        wr(`STT_IDX_RELL, 8'h00);
        wr(`STT_IDX_DIV, 8'h00);
        wr(`STT_IDX_OSC, 8'h00);
        src <= 6'h20;
        wr(`STT_IDX_CTRL, 8'h03);
        repeat (200) @(posedge mclk);
        src <= 6'h00;
        rd(`STT_IDX_CTRL);
        `STT_CHK(rdv, 32'h0000_0083)
        rd(`STT_IDX_STAT);
        `STT_CHK(rdv, 32'h0000_0003)
        pins(2'b01);
        wr(`STT_IDX_MASK, 8'h01);
        pins(2'b11);
        wr(`STT_IDX_STAT, 8'h03);
        pins(2'b01);
        rd(`STT_IDX_STAT);
        `STT_CHK(rdv, 32'h0000_0000)
        wr(`STT_IDX_CTRL, 8'h61);
        rd(`STT_IDX_CTRL);
        `STT_CHK(rdv, 32'h0000_0001)
        pins(2'b00);
        wdt_irq <= 1'b1;
        pins(2'b01);
        wdt_irq <= 1'b0;
        wr(`STT_IDX_RELH, 8'h5a);
        wdt_reset <= 1'b1;
        @(posedge mclk);
        wdt_reset <= 1'b0;
        rd(`STT_IDX_CTRL);
        `STT_CHK(rdv, 32'h0000_0060)
        rd(`STT_IDX_RELH);
        `STT_CHK(rdv, 32'h0000_0000)
        wrap_up();
    end
endmodule
`default_nettype wire
